// File: accel_regs_pkg.sv
// shared constants for the accelerometer read-side register bank
`default_nettype none
package accel_regs_pkg;

  // ==========================================================
  // widths
  localparam int AXES = 3;
  localparam int RESULT_W = 20;
  localparam int TRIM_W = 16;
  localparam int TEMP_W = 12;
  localparam int WORD_W = 24;

  // ==========================================================
  // register addresses
  localparam logic [7:0] TEMP_HIGH_ADDR = 8'h06;
  localparam logic [7:0] TEMP_LOW_ADDR = 8'h07;
  localparam logic [7:0] X_TOP_ADDR = 8'h08;
  localparam logic [7:0] X_MIDDLE_ADDR = 8'h09;
  localparam logic [7:0] X_LOW_ADDR = 8'h0a;
  localparam logic [7:0] Y_TOP_ADDR = 8'h0b;
  localparam logic [7:0] Y_MIDDLE_ADDR = 8'h0c;
  localparam logic [7:0] Y_LOW_ADDR = 8'h0d;
  localparam logic [7:0] Z_TOP_ADDR = 8'h0e;
  localparam logic [7:0] Z_MIDDLE_ADDR = 8'h0f;
  localparam logic [7:0] Z_LOW_ADDR = 8'h10;
  localparam logic [7:0] FIFO_PORT_ADDR = 8'h11;
  localparam logic [7:0] X_TRIM_HIGH_ADDR = 8'h1e;
  localparam logic [7:0] X_TRIM_LOW_ADDR = 8'h1f;
  localparam logic [7:0] Y_TRIM_HIGH_ADDR = 8'h20;
  localparam logic [7:0] Y_TRIM_LOW_ADDR = 8'h21;
  localparam logic [7:0] Z_TRIM_HIGH_ADDR = 8'h22;
  localparam logic [7:0] Z_TRIM_LOW_ADDR = 8'h23;

  // ==========================================================
  // layout steps, reset values and queue word sequencing
  localparam logic [7:0] AXIS_STRIDE = 8'h03;
  localparam logic [7:0] TRIM_STRIDE = 8'h02;
  localparam logic [7:0] NEXT_ADDR_STEP = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
  localparam logic [1:0] FIRST_BYTE_IDX = 2'h0;
  localparam logic [1:0] SECOND_BYTE_IDX = 2'h1;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

endpackage
`default_nettype wire

// File: accel_regs.sv
// accelerometer result, queue port and offset trim register bank
//
// Functional notes
// - x result bytes 19..12, 11..4, 3..0
// - y result, same layout, next three addresses
// - z result, same layout, next three addresses
// - twos complement, left justified, low nibble zero
// - queue word is three bytes, msb first
// - queue port read pops one three-byte word
// - continued queue reads pop every third byte
// - multibyte read at queue port holds pointer
// - reaching queue port by increment: zeros, advance
// - x trim added to result bits 19..4
// - y trim read-write pair, added likewise
// - z trim added likewise after processing
// - 12-bit temperature, low byte live, unbuffered
`timescale 1ns/1ps
`default_nettype none
module accel_regs
(
  input wire logic ref_clk, // 250 MHz core clock
  input wire logic sys_rst, // async reset, active high
  input wire logic xfer_start, // pulse: new transfer, address given
  input wire logic [7:0] xfer_addr, // start address of the transfer
  input wire logic rd_strobe, // pulse: host takes one byte
  input wire logic wr_strobe, // pulse: host writes one byte
  input wire logic [7:0] wr_data, // byte being written
  output logic [7:0] rd_data, // byte read, from flop
  output logic rd_valid, // pulse: rd_data holds the new byte
  input wire logic [accel_regs_pkg::RESULT_W-1:0] raw_x, // filtered x
  input wire logic [accel_regs_pkg::RESULT_W-1:0] raw_y, // filtered y
  input wire logic [accel_regs_pkg::RESULT_W-1:0] raw_z, // filtered z
  input wire logic raw_valid, // pulse: new x, y, z sample
  input wire logic [accel_regs_pkg::TEMP_W-1:0] temp_raw, // live temp
  input wire logic [accel_regs_pkg::WORD_W-1:0] fifo_word, // queue head
  input wire logic fifo_empty, // queue holds no word
  output logic fifo_pop // pulse: head word taken
);
  import accel_regs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ptr;
    logic fifo_mode;
    logic [1:0] byte_idx;
    logic [WORD_W-1:0] hold;
    logic [7:0] rdata;
    logic rvalid;
    logic [AXES-1:0][RESULT_W-1:0] accel;
    logic [AXES-1:0][TRIM_W-1:0] trim;
  } state_t;

  state_t s;
  state_t next_s;
  logic [7:0] cur_addr;
  logic cur_fifo_mode;
  logic rd_fifo_word;
  logic rd_fifo_skip;
  logic [7:0] map_byte;
  logic [AXES-1:0][RESULT_W-1:0] raw_all;
  logic [AXES-1:0][RESULT_W-1:0] trimmed;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // trim addition, one adder per axis
  // the sum wraps rather than saturates; trim range is left to software
  assign raw_all = {raw_z, raw_y, raw_x};
  generate
    for (genvar i = 0; i < AXES; i++)
    begin : g_trim
      assign trimmed[i] = raw_all[i] + {s.trim[i], RESERVED_NIBBLE};
    end
  endgenerate

  // ==========================================================
  // address in force this cycle; a start in the same cycle wins
  assign cur_addr = xfer_start ? xfer_addr : s.ptr;
  assign cur_fifo_mode = xfer_start ? (xfer_addr == FIFO_PORT_ADDR)
                                    : s.fifo_mode;
  assign rd_fifo_word = rd_strobe && (cur_addr == FIFO_PORT_ADDR)
                        && cur_fifo_mode;
  assign rd_fifo_skip = rd_strobe && (cur_addr == FIFO_PORT_ADDR)
                        && !cur_fifo_mode;

  // ==========================================================
  // read map of the plain registers; the queue port is handled apart
  always_comb
  begin
    logic [7:0] axis_base;
    logic [7:0] trim_base;
    axis_base = X_TOP_ADDR;
    trim_base = X_TRIM_HIGH_ADDR;
    map_byte = RESET_BYTE;
    // temperature is read live, so the two halves may tear
    if (cur_addr == TEMP_HIGH_ADDR)
      map_byte = {RESERVED_NIBBLE, temp_raw[TEMP_W-1:8]};
    if (cur_addr == TEMP_LOW_ADDR)
      map_byte = temp_raw[7:0];
    for (int i = 0; i < AXES; i++)
    begin
      axis_base = X_TOP_ADDR + AXIS_STRIDE * 8'(i);
      trim_base = X_TRIM_HIGH_ADDR + TRIM_STRIDE * 8'(i);
      if (cur_addr == axis_base)
        map_byte = s.accel[i][19:12];
      if (cur_addr == axis_base + NEXT_ADDR_STEP)
        map_byte = s.accel[i][11:4];
      if (cur_addr == axis_base + TRIM_STRIDE)
        map_byte = {s.accel[i][3:0], RESERVED_NIBBLE};
      if (cur_addr == trim_base)
        map_byte = s.trim[i][15:8];
      if (cur_addr == trim_base + NEXT_ADDR_STEP)
        map_byte = s.trim[i][7:0];
    end
  end

  // ==========================================================
  // next state: pointer, queue sequencing, results and trims
  always_comb
  begin
    logic [7:0] trim_base;
    trim_base = X_TRIM_HIGH_ADDR;
    next_s = s;
    next_s.rvalid = 1'b0;
    fifo_pop = 1'b0;
    if (xfer_start)
    begin
      next_s.ptr = xfer_addr;
      next_s.fifo_mode = (xfer_addr == FIFO_PORT_ADDR);
    end
    // new sample replaces all three results at once
    if (raw_valid)
      next_s.accel = trimmed;
    if (rd_fifo_word)
    begin
      // pointer stays on the queue port for the whole transfer
      next_s.ptr = FIFO_PORT_ADDR;
      next_s.rvalid = 1'b1;
      if (s.byte_idx == FIRST_BYTE_IDX)
      begin
        // an empty queue gives a zero word and pops nothing
        fifo_pop = !fifo_empty;
        next_s.hold = fifo_empty ? {WORD_W{1'b0}} : fifo_word;
        next_s.rdata = fifo_empty ? RESET_BYTE : fifo_word[23:16];
        next_s.byte_idx = SECOND_BYTE_IDX;
      end
      else if (s.byte_idx == SECOND_BYTE_IDX)
      begin
        next_s.rdata = s.hold[15:8];
        next_s.byte_idx = LAST_BYTE_IDX;
      end
      else
      begin
        next_s.rdata = s.hold[7:0];
        next_s.byte_idx = FIRST_BYTE_IDX;
      end
    end
    else if (rd_fifo_skip)
    begin
      // arrived by increment: no pop, zeros, move on
      next_s.rdata = RESET_BYTE;
      next_s.rvalid = 1'b1;
      next_s.ptr = cur_addr + NEXT_ADDR_STEP;
      next_s.fifo_mode = 1'b0;
    end
    else if (rd_strobe)
    begin
      // any other register read abandons a part-read queue word
      next_s.rdata = map_byte;
      next_s.rvalid = 1'b1;
      next_s.ptr = cur_addr + NEXT_ADDR_STEP;
      next_s.fifo_mode = 1'b0;
      next_s.byte_idx = FIRST_BYTE_IDX;
    end
    else if (wr_strobe)
    begin
      // only the trim pairs take writes; others are ignored
      for (int i = 0; i < AXES; i++)
      begin
        trim_base = X_TRIM_HIGH_ADDR + TRIM_STRIDE * 8'(i);
        if (cur_addr == trim_base)
          next_s.trim[i][15:8] = wr_data;
        if (cur_addr == trim_base + NEXT_ADDR_STEP)
          next_s.trim[i][7:0] = wr_data;
      end
      next_s.ptr = cur_addr + NEXT_ADDR_STEP;
      next_s.fifo_mode = 1'b0;
    end
  end

  // ==========================================================
  // state register; every field resets to zero
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign rd_data = s.rdata;
  assign rd_valid = s.rvalid;

  // ==========================================================
  // checks on the queue port sequencing
  sequence word_start_s;
    rd_fifo_word && (s.byte_idx == FIRST_BYTE_IDX) && !fifo_empty;
  endsequence

  sequence later_byte_s;
    rd_fifo_word && (s.byte_idx != FIRST_BYTE_IDX);
  endsequence

  sequence skip_read_s;
    rd_fifo_skip;
  endsequence

  pop_on_start_a: assert property (word_start_s |-> fifo_pop)
    else $error("queue word not popped on first byte");

  no_mid_pop_a: assert property (later_byte_s |-> !fifo_pop)
    else $error("queue popped before three bytes were sent");

  third_byte_a: assert property (
    (rd_fifo_word && s.byte_idx == LAST_BYTE_IDX)
    |=> (s.byte_idx == FIRST_BYTE_IDX))
    else $error("queue byte count did not wrap after third byte");

  // the head word is caught on the pop edge; later bytes replay the copy
  msb_first_a: assert property (
    fifo_pop |=> (rd_data == $past(fifo_word[23:16])) && rd_valid)
    else $error("first queue byte is not the top byte");

  word_order_a: assert property (
    fifo_pop ##1 later_byte_s |=> rd_data == $past(s.hold[15:8], 1))
    else $error("second queue byte is not the middle byte");

  last_byte_a: assert property (
    (rd_fifo_word && s.byte_idx == LAST_BYTE_IDX)
    |=> rd_data == $past(s.hold[7:0]))
    else $error("third queue byte is not the bottom byte");

  ptr_hold_a: assert property (rd_fifo_word |=> s.ptr == FIFO_PORT_ADDR)
    else $error("pointer moved during a queue port read");

  mode_hold_a: assert property (rd_fifo_word |=> s.fifo_mode)
    else $error("queue mode dropped during a queue port read");

  // a pop without a first-byte read would lose a sample silently
  empty_no_pop_a: assert property (fifo_empty |-> !fifo_pop)
    else $error("queue popped while empty");

  pop_needs_read_a: assert property (
    fifo_pop |-> word_start_s)
    else $error("queue popped without a first-byte read");

  skip_zero_a: assert property (
    skip_read_s |-> !fifo_pop ##1
    (rd_data == RESET_BYTE) && (s.ptr == FIFO_PORT_ADDR + NEXT_ADDR_STEP))
    else $error("queue port reached by increment misbehaved");

  // ==========================================================
  // checks on results, trims and temperature
  x_top_a: assert property (
    (rd_strobe && cur_addr == X_TOP_ADDR)
    |=> rd_data == $past(s.accel[0][19:12]))
    else $error("x top byte read wrong");

  x_low_a: assert property (
    (rd_strobe && cur_addr == X_LOW_ADDR)
    |=> rd_data == {$past(s.accel[0][3:0]), RESERVED_NIBBLE})
    else $error("x low nibble read wrong");

  y_top_a: assert property (
    (rd_strobe && cur_addr == Y_TOP_ADDR)
    |=> rd_data == $past(s.accel[1][19:12]))
    else $error("y top byte read wrong");

  y_middle_a: assert property (
    (rd_strobe && cur_addr == Y_MIDDLE_ADDR)
    |=> rd_data == $past(s.accel[1][11:4]))
    else $error("y middle byte read wrong");

  z_middle_a: assert property (
    (rd_strobe && cur_addr == Z_MIDDLE_ADDR)
    |=> rd_data == $past(s.accel[2][11:4]))
    else $error("z middle byte read wrong");

  z_low_a: assert property (
    (rd_strobe && cur_addr == Z_LOW_ADDR)
    |=> rd_data == {$past(s.accel[2][3:0]), RESERVED_NIBBLE})
    else $error("z low nibble read wrong");

  low_nibble_a: assert property (
    (rd_strobe && (cur_addr == X_LOW_ADDR || cur_addr == Y_LOW_ADDR))
    |=> rd_data[3:0] == RESERVED_NIBBLE)
    else $error("reserved nibble not zero");

  // sums are checked against the trim held before the sample edge
  x_trim_sum_a: assert property (
    raw_valid |=> s.accel[0] == $past(raw_x) + {$past(s.trim[0]),
    RESERVED_NIBBLE})
    else $error("x trim not added at bit 4");

  // a read in the same cycle wins, so write checks leave it out
  x_trim_write_a: assert property (
    (wr_strobe && !rd_strobe && cur_addr == X_TRIM_LOW_ADDR)
    |=> s.trim[0][7:0] == $past(wr_data))
    else $error("x trim low byte not written");

  y_trim_sum_a: assert property (
    raw_valid |=> s.accel[1] == $past(raw_y) + {$past(s.trim[1]),
    RESERVED_NIBBLE})
    else $error("y trim not added at bit 4");

  y_trim_write_a: assert property (
    (wr_strobe && !rd_strobe && cur_addr == Y_TRIM_HIGH_ADDR)
    |=> s.trim[1][15:8] == $past(wr_data))
    else $error("y trim high byte not written");

  z_trim_sum_a: assert property (
    raw_valid |=> s.accel[2] == $past(raw_z) + {$past(s.trim[2]),
    RESERVED_NIBBLE})
    else $error("z trim not added at bit 4");

  z_trim_write_a: assert property (
    (wr_strobe && !rd_strobe && cur_addr == Z_TRIM_HIGH_ADDR)
    |=> s.trim[2][15:8] == $past(wr_data))
    else $error("z trim high byte not written");

  temp_high_a: assert property (
    (rd_strobe && cur_addr == TEMP_HIGH_ADDR)
    |=> rd_data == {RESERVED_NIBBLE, $past(temp_raw[11:8])})
    else $error("temperature high nibble read wrong");

  temp_live_a: assert property (
    (rd_strobe && cur_addr == TEMP_LOW_ADDR)
    |=> rd_data == $past(temp_raw[7:0]))
    else $error("temperature low byte not live");

endmodule
`default_nettype wire

// File: sample_queue_model.sv
// stand-in for the sample store that feeds the queue read port
`timescale 1ns/1ps
`default_nettype none
module sample_queue_model
(
  input wire logic ref_clk, // core clock
  input wire logic fifo_pop, // head word taken this cycle
  output logic [23:0] fifo_word, // head word, msb byte first
  output logic fifo_empty // no word held
);
  logic [23:0] q[$];
  // ==========================================================
  // loading
  // the new head shows from the next edge, like a registered store;
  // after the initial block sets them, only the clocked process below drives the outputs
  task automatic push(input logic [23:0] w);
    q.push_back(w);
  endtask
  initial
  begin
    fifo_word = 24'h5a5a5a;
    fifo_empty = 1'b1;
  end
  // ==========================================================
  // pop on the strobe edge; an empty store churns its word so
  // stale data never passes for a sample
  always @(posedge ref_clk)
  begin
    if (fifo_pop === 1'b1 && q.size() > 0)
      void'(q.pop_front());
    fifo_word <= (q.size() > 0) ? q[0] : ~fifo_word;
    fifo_empty <= (q.size() == 0);
  end
endmodule
`default_nettype wire

// File: accel_regs_test.sv
// self-checking bench for the accelerometer register bank
`timescale 1ns/1ps
`default_nettype none
module accel_regs_test;
  import accel_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic xfer_start = 1'b0;
  logic [7:0] xfer_addr = 8'h00;
  logic rd_strobe = 1'b0;
  logic wr_strobe = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [19:0] rv[3] = '{20'h0, 20'h0, 20'h0};
  logic raw_valid = 1'b0;
  logic [11:0] temp_raw = 12'h000;
  logic [23:0] fifo_word;
  logic fifo_empty;
  logic fifo_pop;
  logic [7:0] exp_q[$];
  logic [7:0] wq[$];
  logic [7:0] exp_b;
  logic [31:0] seed = 32'he27e4638;
  logic [15:0] trim[3];
  logic [19:0] res;
  int fails = 0;
  int num_checks = 0;
  int pops = 0;
  // ==========================================================
  // design and queue model
  accel_regs u_accel_regs (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .xfer_start(xfer_start), .xfer_addr(xfer_addr),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .raw_x(rv[0]),
    .raw_y(rv[1]), .raw_z(rv[2]), .raw_valid(raw_valid),
    .temp_raw(temp_raw), .fifo_word(fifo_word),
    .fifo_empty(fifo_empty), .fifo_pop(fifo_pop));
  sample_queue_model u_sample_queue_model (.ref_clk(ref_clk),
    .fifo_pop(fifo_pop), .fifo_word(fifo_word),
    .fifo_empty(fifo_empty));
  always #2 ref_clk = ~ref_clk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h0);
  endfunction
  task automatic note(input logic [7:0] b);
    exp_q.push_back(b);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // burst read: one strobe a cycle, start pulse only on the first
  task automatic rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      #1;
      xfer_start = (i == 0);
      xfer_addr = a;
      rd_strobe = 1'b1;
    end
    @(posedge ref_clk);
    #1;
    xfer_start = 1'b0;
    rd_strobe = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge ref_clk);
      #1;
      xfer_start = (i == 0);
      xfer_addr = a;
      wr_strobe = 1'b1;
      wr_data = b[i];
    end
    @(posedge ref_clk);
    #1;
    xfer_start = 1'b0;
    wr_strobe = 1'b0;
  endtask
  // bounded wait for every noted byte to come back
  // returns just after an edge, so the next stimulus is off the edge
  task automatic drain(input string t);
    for (int i = 0; i < 8 && exp_q.size() > 0; i++)
      @(posedge ref_clk);
    #1;
    if (exp_q.size() > 0)
    begin
      fails++;
      $display("[FAIL] %0t bytes missing", $time);
      end_of_test;
    end
    else
      $display("test %s done", t);
  endtask
  // ==========================================================
  // watcher: each answer takes the oldest note
  always @(posedge ref_clk)
  begin
    if (fifo_pop === 1'b1)
      pops++;
    if (rd_valid === 1'b1 && exp_q.size() == 0)
    begin
      num_checks++;
      fails++;
      $display("[FAIL] %0t unasked byte %h", $time, rd_data);
    end
    else if (rd_valid === 1'b1)
    begin
      num_checks++;
      exp_b = exp_q.pop_front();
      if (rd_data !== exp_b)
      begin
        fails++;
        $display("[FAIL] %0t byte got %h exp %h", $time, rd_data, exp_b);
      end
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    // reset values, then queue port reached by increment and past it
    for (int i = 0; i < 13; i++)
      note(8'h00);
    rd(TEMP_HIGH_ADDR, 13);
    drain("reset");
    num_checks++;
    if (pops !== 0)
    begin
      fails++;
      $display("[FAIL] %0t pop by increment", $time);
    end
    // trims written as one burst, read back, then added to a sample
    for (int a = 0; a < 3; a++)
    begin
      seed = lfsr(seed);
      trim[a] = seed[15:0];
      wq.push_back(trim[a][15:8]);
      wq.push_back(trim[a][7:0]);
      note(trim[a][15:8]);
      note(trim[a][7:0]);
    end
    wr(X_TRIM_HIGH_ADDR, wq);
    rd(X_TRIM_HIGH_ADDR, 6);
    for (int a = 0; a < 3; a++)
    begin
      seed = lfsr(seed);
      rv[a] = seed[19:0];
      res = rv[a] + {trim[a], 4'h0};
      note(res[19:12]);
      note(res[11:4]);
      note({res[3:0], 4'h0});
    end
    raw_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    raw_valid = 1'b0;
    rd(X_TOP_ADDR, 9);
    drain("trim");
    // live temperature split over two bytes
    seed = lfsr(seed);
    temp_raw = seed[11:0];
    note({4'h0, temp_raw[11:8]});
    note(temp_raw[7:0]);
    rd(TEMP_HIGH_ADDR, 2);
    drain("temperature");
    // queue burst: two words, then an empty store reads as zeros
    for (int w = 0; w < 2; w++)
    begin
      seed = lfsr(seed);
      u_sample_queue_model.push(seed[23:0]);
      note(seed[23:16]);
      note(seed[15:8]);
      note(seed[7:0]);
    end
    for (int i = 0; i < 3; i++)
      note(8'h00);
    rd(FIFO_PORT_ADDR, 9);
    drain("queue");
    num_checks++;
    if (pops !== 2)
    begin
      fails++;
      $display("[FAIL] %0t pops per three bytes", $time);
    end
    // three separate single reads of the queue port finish one word
    seed = lfsr(seed);
    u_sample_queue_model.push(seed[23:0]);
    note(seed[23:16]);
    note(seed[15:8]);
    note(seed[7:0]);
    for (int i = 0; i < 3; i++)
      rd(FIFO_PORT_ADDR, 1);
    drain("single reads");
    num_checks++;
    if (pops !== 3)
    begin
      fails++;
      $display("[FAIL] %0t pops over single reads", $time);
    end
    // mid-run reset clears trims; writes off the trim pairs are dropped
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    seed = lfsr(seed);
    wq.delete();
    wq.push_back(seed[7:0]);
    wq.push_back(seed[15:8]);
    wr(TEMP_LOW_ADDR, wq);
    for (int i = 0; i < 7; i++)
      note(8'h00);
    rd(X_TOP_ADDR, 1);
    rd(X_TRIM_HIGH_ADDR, 6);
    drain("reset again");
    end_of_test;
  end
endmodule
`default_nettype wire
